// File: rtl/pbs_core.sv
// pipelined burst static memory core with late write and its write buffer
`timescale 1ns/1ps


// ---------------------------------------------------------------
// write buffer
// ---------------------------------------------------------------
module pbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam logic [PTR_W:0] COUNT_FULL = (PTR_W+1)'(DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("pbs_fifo: depth must be at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [PTR_W:0] count_reg;
   wire push = clk_en & in_valid & in_ready;
   wire pop = clk_en & out_valid & out_ready;

   assign in_ready = (count_reg != COUNT_FULL);
   assign out_valid = (count_reg != '0);
   assign out_data = store_reg[rd_ptr_reg];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= in_data;
      end
   end
endmodule // pbs_fifo

// ---------------------------------------------------------------
// memory core
// ---------------------------------------------------------------
module pbs_core #(
   parameter int WBUF_DEPTH = pbs_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic clock_hold_n,
   input wire logic chip_select_0,
   input wire logic chip_select_1,
   input wire logic chip_select_2,
   input wire logic advance_load,
   input wire logic read_not_write,
   input wire logic [pbs_pkg::LANES-1:0] byte_write_n,
   input wire logic [pbs_pkg::ADDR_W-1:0] address,
   input wire logic drive_enable_n,
   input wire logic burst_order_select_n,
   input wire logic sleep_request,
   input wire logic [pbs_pkg::DATA_W-1:0] dq_in,
   output logic [pbs_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic write_buffer_ready
);
   import pbs_pkg::*;

   generate
      if (WBUF_DEPTH < 2) begin : g_bad
         $error("pbs_core: write buffer depth must be at least 2");
      end
   endgenerate

   // ---------------------------------------------------------------
   // asynchronous pins
   // ---------------------------------------------------------------
   logic [SYNC_N-1:0] sync_a_reg;
   logic [SYNC_N-1:0] sync_b_reg;
   logic [SYNC_N-1:0] sync_c_reg;
   logic [SYNC_N-1:0] sync_reg;
   logic [SYNC_N-1:0] sync_next;
   wire [SYNC_N-1:0] sync_agree = ~(sync_b_reg ^ sync_c_reg);

   // a change is accepted only once stages two and three agree
   assign sync_next = (sync_b_reg & sync_agree) | (sync_reg & ~sync_agree);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a_reg <= SYNC_RST;
         sync_b_reg <= SYNC_RST;
         sync_c_reg <= SYNC_RST;
         sync_reg <= SYNC_RST;
      end else if (clk_en) begin
         sync_a_reg <= {burst_order_select_n, drive_enable_n, sleep_request};
         sync_b_reg <= sync_a_reg;
         sync_c_reg <= sync_b_reg;
         sync_reg <= sync_next;
      end
   end

   wire sleep_q = sync_reg[SY_SLEEP];
   wire drive_off = sync_reg[SY_DRV_N];
   wire linear_order = ~sync_reg[SY_ORDER_N];

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   pbs_burst_t burst_reg;
   pbs_burst_t burst_next;
   logic [ADDR_W-1:0] base_reg;
   logic [BURST_W-1:0] step_reg;
   pbs_op_t s1_reg;
   pbs_op_t s2_reg;
   pbs_op_t op_next;
   logic rd_phase_reg;
   logic [DATA_W-1:0] dq_out_reg;
   logic dq_oe_reg;
   logic wbuf_ready_reg;
   logic [DATA_W-1:0] mem [2**ADDR_W];

   logic wr_in_ready;
   logic wr_out_valid;
   pbs_wr_t wr_in;
   pbs_wr_t wr_out;

   wire selected = ~chip_select_0 & chip_select_1 & ~chip_select_2;
   wire load = ~advance_load;
   wire [BURST_W-1:0] step_inc = step_reg + STEP_ONE;
   wire [BURST_W-1:0] base_low = base_reg[BURST_W-1:0];
   wire [BURST_W-1:0] low_next = linear_order ? base_low + step_inc
                                              : base_low ^ step_inc;
   wire [ADDR_W-1:0] burst_addr = {base_reg[ADDR_W-1:BURST_W], low_next};
   wire s2_write = s2_reg.valid & s2_reg.write;
   wire wr_push = s2_write & ~&s2_reg.bw_n;
   // a full buffer stalls the pipeline rather than lose write data
   wire wbuf_block = wr_push & ~wr_in_ready;
   wire run = clk_en & ~clock_hold_n & ~sleep_q & ~wbuf_block;

   assign burst_next = !load ? burst_reg :
                       !selected ? BURST_IDLE :
                       read_not_write ? BURST_READ : BURST_WRITE;

   always_comb begin
      op_next = OP_NONE;
      if (load) begin
         op_next.valid = selected;
         op_next.write = ~read_not_write;
         op_next.addr = address;
      end else begin
         op_next.valid = (burst_reg != BURST_IDLE);
         op_next.write = (burst_reg == BURST_WRITE);
         op_next.addr = burst_addr;
      end
      op_next.bw_n = byte_write_n;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         burst_reg <= BURST_IDLE;
         base_reg <= '0;
         step_reg <= STEP_ZERO;
         s1_reg <= OP_NONE;
         s2_reg <= OP_NONE;
      end else if (clk_en && sleep_q) begin
         burst_reg <= BURST_IDLE;
         s1_reg <= OP_NONE;
         s2_reg <= OP_NONE;
      end else if (run) begin
         burst_reg <= burst_next;
         if (load && selected) begin
            base_reg <= address;
         end
         step_reg <= load ? STEP_ZERO : step_inc;
         s1_reg <= op_next;
         s2_reg <= s1_reg;
      end
   end

   // ---------------------------------------------------------------
   // write path
   // ---------------------------------------------------------------
   always_comb begin
      wr_in.addr = s2_reg.addr;
      wr_in.data = dq_in;
      wr_in.lane_en = ~s2_reg.bw_n;
   end

   pbs_fifo #(
      .WIDTH($bits(pbs_wr_t)),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .clk(clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .in_valid(wr_push & run),
      .in_ready(wr_in_ready),
      .in_data(wr_in),
      .out_valid(wr_out_valid),
      // the array sleeps with the rest of the core
      .out_ready(~sleep_q),
      .out_data(wr_out)
   );

   wire drain = clk_en & wr_out_valid & ~sleep_q;

   always_ff @(posedge clk) begin
      for (int l = 0; l < LANES; l++) begin
         if (drain && wr_out.lane_en[l]) begin
            mem[wr_out.addr][l*LANE_W +: LANE_W] <=
               wr_out.data[l*LANE_W +: LANE_W];
         end
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   // newest data wins: pins of a write in flight, then buffer head
   wire pin_hit = s2_write & (s2_reg.addr == s1_reg.addr);
   wire head_hit = wr_out_valid & (wr_out.addr == s1_reg.addr);
   wire [DATA_W-1:0] mem_word = mem[s1_reg.addr];
   logic [DATA_W-1:0] rd_word;

   always_comb begin
      rd_word = mem_word;
      for (int l = 0; l < LANES; l++) begin
         if (pin_hit && !s2_reg.bw_n[l]) begin
            rd_word[l*LANE_W +: LANE_W] = dq_in[l*LANE_W +: LANE_W];
         end else if (head_hit && wr_out.lane_en[l]) begin
            rd_word[l*LANE_W +: LANE_W] = wr_out.data[l*LANE_W +: LANE_W];
         end
      end
   end

   wire s1_read = s1_reg.valid & ~s1_reg.write;
   // a held clock keeps the phase, so reads stay driven, writes float
   wire rd_phase_next = sleep_q ? 1'b0 : run ? s1_read : rd_phase_reg;
   wire oe_next = rd_phase_next & ~drive_off & ~sleep_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_phase_reg <= 1'b0;
         dq_out_reg <= DATA_ZERO;
         dq_oe_reg <= 1'b0;
         wbuf_ready_reg <= 1'b1;
      end else if (clk_en) begin
         rd_phase_reg <= rd_phase_next;
         dq_oe_reg <= oe_next;
         wbuf_ready_reg <= wr_in_ready;
         if (run && s1_read) begin
            dq_out_reg <= rd_word;
         end
      end
   end

   assign dq_out = dq_out_reg;
   assign dq_oe = dq_oe_reg;
   assign write_buffer_ready = wbuf_ready_reg;
endmodule // pbs_core

// File: rtl/pbs_pkg.sv
// shared constants and carrier types of the pipelined burst memory core
package pbs_pkg;
   localparam int DATA_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 2;
   localparam int ADDR_W = 20;
   localparam int BURST_W = 2;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_N = 3;
   // synchroniser bit positions
   localparam int SY_SLEEP = 0;
   localparam int SY_DRV_N = 1;
   localparam int SY_ORDER_N = 2;
   localparam logic [SYNC_N-1:0] SYNC_RST = 3'h6;
   localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
   localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;
   localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;

   typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} pbs_burst_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] bw_n;
   } pbs_op_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0] lane_en;
   } pbs_wr_t;

   localparam pbs_op_t OP_NONE = '{valid: 1'b0, write: 1'b0,
      addr: '0, bw_n: '1};
endpackage

// File: tb/pbs_core_checker.sv
// pin-level checks of the burst memory core
`timescale 1ns/1ps
module pbs_core_checker (
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic clock_hold_n,
   input wire logic chip_select_0,
   input wire logic chip_select_1,
   input wire logic chip_select_2,
   input wire logic advance_load,
   input wire logic read_not_write,
   input wire logic drive_enable_n,
   input wire logic sleep_request,
   input wire logic [pbs_pkg::DATA_W-1:0] dq_out,
   input wire logic dq_oe
);
   import pbs_pkg::*;
   // ----------------
   // command decode
   // ----------------
   wire logic run = clk_en && !clock_hold_n && !sleep_request;
   wire logic sel = !chip_select_0 && chip_select_1 && !chip_select_2;
   wire logic ld = run && !advance_load;
   wire logic adv = run && advance_load;
   // async pins pass a synchroniser, so they must settle for six edges
   wire logic quiet = !drive_enable_n && !sleep_request;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_rst; $rose(resetn) |-> !dq_oe; endproperty
   a_rst: assert property (p_rst) else $error("drive after reset");
   property p_off; drive_enable_n [*6] |-> !dq_oe; endproperty
   a_off: assert property (p_off) else $error("drive while off");
   property p_zz; sleep_request [*6] |-> !dq_oe; endproperty
   a_zz: assert property (p_zz) else $error("drive in sleep");
   property p_hold;
      clk_en && clock_hold_n && !sleep_request |=>
         $stable(dq_out) && $stable(dq_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("moved in hold");
   property p_frz; !clk_en |=> $stable(dq_out) && $stable(dq_oe); endproperty
   a_frz: assert property (p_frz) else $error("moved while frozen");
   property p_wr; ld && sel && !read_not_write ##1 run |=> !dq_oe; endproperty
   a_wr: assert property (p_wr) else $error("drive on write");
   property p_rd;
      quiet [*6] ##0 ld && sel && read_not_write ##1 run |=> dq_oe;
   endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_ds; ld && !sel ##1 run |=> !dq_oe; endproperty
   a_ds: assert property (p_ds) else $error("drive on deselect");
   property p_cds; ld && !sel ##1 adv ##1 run |=> !dq_oe; endproperty
   a_cds: assert property (p_cds) else $error("advance drove");
   property p_brd;
      quiet [*6] ##0 ld && sel && read_not_write ##1 adv ##1 run |=> dq_oe;
   endproperty
   a_brd: assert property (p_brd) else $error("burst not read");
endmodule // pbs_core_checker

bind pbs_core pbs_core_checker u_chk (.*);

// File: tb/pbs_host_model.sv
// host data lane: late write data, toggling level when idle
`timescale 1ns/1ps
module pbs_host_model (
   input wire logic clk,
   input wire logic clk_en,
   input wire logic clock_hold_n,
   input wire logic wr_go,
   input wire logic [pbs_pkg::DATA_W-1:0] wr_data,
   output logic [pbs_pkg::DATA_W-1:0] dq_in
);
   import pbs_pkg::*;
   logic go_reg = 1'b0;
   logic [DATA_W-1:0] data_reg = DATA_ZERO;
   initial dq_in = DATA_ZERO;
   // -------------
   // data lane
   // -------------
   // a stalled edge moves nothing, the word waits with the device
   always @(posedge clk) begin
      if (clk_en && !clock_hold_n) begin
         go_reg <= wr_go;
         data_reg <= wr_data;
         dq_in <= go_reg ? data_reg : ~dq_in;
      end
   end
endmodule // pbs_host_model

// File: tb/pbs_core_tb.sv
// bench of the burst memory core
`timescale 1ns/1ps
module pbs_core_tb;
   import pbs_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, clock_hold_n = 1'b0;
   logic chip_select_0 = 1'b1, chip_select_1 = 1'b0, chip_select_2 = 1'b1;
   logic advance_load = 1'b0, read_not_write = 1'b1, wr_go = 1'b0;
   logic drive_enable_n = 1'b0, burst_order_select_n = 1'b1;
   logic sleep_request = 1'b0, dq_oe, write_buffer_ready;
   logic [1:0] byte_write_n = 2'h3;
   logic [1:0] lo;
   logic [ADDR_W-1:0] address = 20'h00000;
   logic [DATA_W-1:0] wr_data = 18'h00000, dq_in, dq_out, d;
   // expectation pipe: check flag, drive expected, data
   logic [19:0] pend = 20'h00000, s1 = 20'h00000, s2 = 20'h00000;
   int n_mismatch = 0, num_checks = 0;
   always #25 clk = ~clk;
   pbs_core dut (.*);
   pbs_host_model host (.*);
   // -------------
   // tasks
   // -------------
   task automatic chk(input string what, input logic [17:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(input logic adv, rnw, wr, input logic [1:0] bw,
      input logic [19:0] a, p);
      @(posedge clk);
      clock_hold_n <= 1'b0;
      advance_load <= adv;
      chip_select_0 <= adv;
      chip_select_1 <= 1'b1;
      chip_select_2 <= 1'b0;
      read_not_write <= rnw;
      byte_write_n <= bw;
      address <= a;
      wr_go <= wr;
      wr_data <= p[17:0];
      pend <= p;
   endtask
   task automatic desel(input int k);
      @(posedge clk);
      clock_hold_n <= 1'b0;
      advance_load <= 1'b0;
      chip_select_0 <= k == 0;
      chip_select_1 <= k != 1;
      chip_select_2 <= k == 2;
      wr_go <= 1'b0;
      pend <= 20'h80000;
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (s2[19]) begin
         chk("drive", {17'h00000, s2[18]}, {17'h00000, dq_oe});
         if (s2[18]) chk("data", s2[17:0], dq_out);
      end
      if (clk_en && !clock_hold_n) begin
         s2 <= s1;
         s1 <= pend;
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_mismatch++;
      give_verdict();
   end
   // -------------
   // tests
   // -------------
   initial begin
      repeat (20) @(posedge clk);
      chk("idle", 18'h00000, {17'h00000, dq_oe});
      resetn <= 1'b1;
      repeat (6) desel(0);
      $display("test reset done");
      op(0, 0, 1, 2'h0, 20'hA5551, {2'b10, 18'h2AB55});
      op(0, 0, 1, 2'h1, 20'hA5551, {2'b10, 18'h15A33});
      op(0, 0, 1, 2'h0, 20'hA5552, {2'b10, 18'h0F0F0});
      op(0, 0, 1, 2'h3, 20'hA5552, {2'b10, 18'h3FFFF});
      op(0, 1, 0, 2'h3, 20'hA5551, {2'b11, 9'h0AD, 9'h155});
      op(0, 1, 0, 2'h3, 20'hA5552, {2'b11, 18'h0F0F0});
      for (int k = 0; k < 3; k++) begin
         desel(k);
         op(1, 0, 0, 2'h3, 20'h00000, 20'h80000);
      end
      repeat (2) desel(0);
      $display("test write_read done");
      for (int o = 0; o < 2; o++) begin
         burst_order_select_n <= o[0];
         repeat (6) desel(0);
         for (int i = 0; i < 4; i++) begin
            d = {10'h123, 2'(o), 2'h0, 4'(i)};
            op(i != 0, i != 0, 1, 2'h0, {17'h16A60 + 17'(o), 3'h1},
               {2'b10, d});
         end
         for (int i = 0; i < 4; i++) begin
            d = {10'h123, 2'(o), 2'h0, 4'(i)};
            lo = o ? 2'h1 ^ 2'(i) : 2'h1 + 2'(i);
            op(0, 1, 0, 2'h3, {17'h16A60 + 17'(o), 1'b0, lo},
               {2'b11, d});
         end
         for (int i = 0; i < 4; i++) begin
            d = {10'h123, 2'(o), 2'h0, 4'(i)};
            op(i != 0, i == 0, 0, 2'h3, {17'h16A60 + 17'(o), 3'h1},
               {2'b11, d});
            if (i == 2) begin
               @(posedge clk);
               clock_hold_n <= 1'b1;
               advance_load <= 1'b0;
               repeat (2) @(posedge clk);
            end
         end
         repeat (2) desel(0);
      end
      $display("test burst done");
      drive_enable_n <= 1'b1;
      repeat (6) desel(0);
      op(0, 1, 0, 2'h3, 20'hA5552, 20'h80000);
      repeat (2) desel(0);
      drive_enable_n <= 1'b0;
      repeat (6) desel(0);
      $display("test drive done");
      sleep_request <= 1'b1;
      repeat (6) desel(0);
      op(0, 0, 1, 2'h0, 20'hA5552, {2'b10, 18'h3FFFF});
      op(0, 1, 0, 2'h3, 20'hA5552, 20'h80000);
      desel(0);
      sleep_request <= 1'b0;
      repeat (6) desel(0);
      chk("ready", 18'h00001, {17'h00000, write_buffer_ready});
      op(0, 1, 0, 2'h3, 20'hA5552, {2'b11, 18'h0F0F0});
      // a frozen core must hold its outputs; the standing read repeats
      @(posedge clk);
      clk_en <= 1'b0;
      repeat (2) @(posedge clk);
      clk_en <= 1'b1;
      repeat (2) desel(0);
      $display("test sleep done");
      give_verdict();
   end
endmodule // pbs_core_tb
